// ==== lts_pkg.sv ====
// lts_pkg: constants, register map and types of the low-power touch scan controller
// assumes a single 250 MHz system clock and a plain register port
`default_nettype none

package lts_pkg;

  localparam int          LTS_NCH = 4;
  localparam int          LTS_CHW = 2;
  localparam int          LTS_RES_W = 16;
  localparam int          LTS_NIRQ = 4;

  // register byte offsets
  localparam logic [7:0]  LTS_OFF_CTRL_A_LOW  = 8'h00;
  localparam logic [7:0]  LTS_OFF_CTRL_A_HIGH = 8'h04;
  localparam logic [7:0]  LTS_OFF_CTRL_B_LOW  = 8'h08;
  localparam logic [7:0]  LTS_OFF_OFFSET_0    = 8'h0c;
  localparam logic [7:0]  LTS_OFF_OFFSET_1    = 8'h10;
  localparam logic [7:0]  LTS_OFF_RESULT      = 8'h14;
  localparam logic [7:0]  LTS_OFF_CHAN        = 8'h18;
  localparam logic [7:0]  LTS_OFF_TIMER       = 8'h1c;
  localparam logic [7:0]  LTS_OFF_STATUS      = 8'h20;
  localparam logic [7:0]  LTS_OFF_MASK        = 8'h24;
  localparam logic [7:0]  LTS_OFF_STATE       = 8'h28;

  // sense_ctrl_a_low bits
  localparam int          LTS_CAL_START  = 0;
  localparam int          LTS_CAL_TRIG   = 1;
  localparam int          LTS_CAL_SLEEP  = 2;
  localparam int          LTS_CAL_SCAN   = 3;
  localparam int          LTS_CAL_METHOD = 4;
  localparam int          LTS_CAL_BOOST  = 5;
  // sense_ctrl_a_high bits
  localparam int          LTS_CAH_IDLE_LSB = 0;
  localparam int          LTS_CAH_DPSEL    = 2;
  localparam int          LTS_CAH_CLKMODE  = 3;
  // timer control bits
  localparam int          LTS_TMR_RUN  = 0;
  localparam int          LTS_TMR_LINK = 1;
  // status / mask bits
  localparam int          LTS_IRQ_END   = 0;
  localparam int          LTS_IRQ_WRREQ = 1;
  localparam int          LTS_IRQ_RDREQ = 2;
  localparam int          LTS_IRQ_DROP  = 3;

  localparam logic [1:0]  LTS_IDLE_LOW   = 2'h0;
  localparam logic [1:0]  LTS_IDLE_HIGH  = 2'h1;
  localparam logic [1:0]  LTS_IDLE_HIZ   = 2'h2;
  localparam logic [1:0]  LTS_IDLE_PULSE = 2'h3;

  localparam logic [7:0]  LTS_RST_BYTE = 8'h00;

  // timing
  localparam int          LTS_CLK_PERIOD_NS   = 4;
  localparam int          LTS_TICK_PERIOD_MS  = 100;
  localparam int          LTS_TICK_PERIOD_CYC = LTS_TICK_PERIOD_MS * 1000000 / LTS_CLK_PERIOD_NS;
  localparam int          LTS_SENSOR_UNIT_CLOCK_HALF_NS   = 250;
  localparam int          LTS_SENSOR_UNIT_CLOCK_HALF_CYC  = LTS_SENSOR_UNIT_CLOCK_HALF_NS / LTS_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LTS_ST_IDLE,
    LTS_ST_WAIT,
    LTS_ST_WRREQ,
    LTS_ST_SETTLE,
    LTS_ST_COUNT,
    LTS_ST_RDREQ
  } lts_state_t;

endpackage

`default_nettype wire

// ==== lts_scan_ctrl.sv ====
// lts_scan_ctrl: interval timer, event link and capacitive scan sequencer
// assumes a transfer controller that services the request pulses over the register port
// Function
// - interval timer pulses its tick event once at the end of each 100 ms period.
// - event link passes the timer tick to the scan trigger input without software.
// - method bit 0 selects self-capacitance: the measured pin carries the drive pulse.
// - scan mode bit 1 measures channels zero through the one in the channel register per trigger.
// - trigger select bit 1 starts scans only from the linked timer event.
// - sleep run enable 1 lets a triggered scan run while the cpu is stopped.
// - boost power bit 1 turns the boost supply on during measurement.
// - idle pin select 00 drives all non-measured pins low while measuring.
// - drive select and clock mode both 1 take drive pulse from sensor unit clock.
// - settle wait field plus one sensor clock ticks precede counting.
// - measure count is two upper bits and six lower bits from two registers.
// - each channel raises a setting write request before it is measured.
// - after all channels an end interrupt fires and the unit returns to standby.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module lts_scan_ctrl
  import lts_pkg::*;
#(
  parameter int TICK_PERIOD_CYC = LTS_TICK_PERIOD_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 cpu_stopped,
  input  wire logic                 sense_in,
  output logic      [LTS_NCH-1:0]   ts_out,
  output logic      [LTS_NCH-1:0]   ts_oe,
  output logic                      boost_on,
  output logic                      interval_tick_event,
  output logic                      setting_write_request,
  output logic                      result_read_request,
  output logic                      measure_end_irq,
  output logic                      sleep_peripheral_run,
  output logic                      irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]            cal_reg, cah_reg, cbl_reg;
  logic [5:0]            off0_reg;
  logic [1:0]            off1_reg;
  logic [LTS_CHW-1:0]    chan_reg;
  logic [1:0]            tmr_ctl_reg;
  logic [LTS_NIRQ-1:0]   status_reg, status_next, mask_reg, irq_set;
  logic [31:0]           rdata_reg, rdata_next;
  logic [LTS_RES_W-1:0]  result_reg, result_next;
  lts_state_t            state_reg, state_next;
  logic [LTS_CHW-1:0]    ch_reg, ch_next;

  wire wr_cal  = reg_wr && hit(reg_addr, LTS_OFF_CTRL_A_LOW);
  wire wr_off0 = reg_wr && hit(reg_addr, LTS_OFF_OFFSET_0);
  wire wr_stat = reg_wr && hit(reg_addr, LTS_OFF_STATUS);
  wire rd_res  = reg_rd && hit(reg_addr, LTS_OFF_RESULT);

  wire       sw_trig    = cal_reg[LTS_CAL_TRIG];
  wire       sleep_en   = cal_reg[LTS_CAL_SLEEP];
  wire       scan_multi = cal_reg[LTS_CAL_SCAN];
  wire       method_mut = cal_reg[LTS_CAL_METHOD];
  wire [1:0] idle_sel   = cah_reg[LTS_CAH_IDLE_LSB +: 2];
  wire       su_drive   = cah_reg[LTS_CAH_DPSEL] && cah_reg[LTS_CAH_CLKMODE];
  wire [7:0] meas_n     = {off1_reg, off0_reg};

  // start bit: software sets, hardware clears at the end of a software-started scan
  wire sw_scan_end;
  wire start_next = wr_cal ? reg_wdata[LTS_CAL_START] : (cal_reg[LTS_CAL_START] && !sw_scan_end);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cal_reg     <= LTS_RST_BYTE;
      cah_reg     <= LTS_RST_BYTE;
      cbl_reg     <= LTS_RST_BYTE;
      off0_reg    <= '0;
      off1_reg    <= '0;
      chan_reg    <= '0;
      tmr_ctl_reg <= '0;
      mask_reg    <= '0;
    end else begin
      if (wr_cal) cal_reg <= reg_wdata[7:0];
      cal_reg[LTS_CAL_START] <= start_next;
      if (reg_wr && hit(reg_addr, LTS_OFF_CTRL_A_HIGH)) cah_reg <= reg_wdata[7:0];
      if (reg_wr && hit(reg_addr, LTS_OFF_CTRL_B_LOW)) cbl_reg <= reg_wdata[7:0];
      if (wr_off0) off0_reg <= reg_wdata[5:0];
      if (reg_wr && hit(reg_addr, LTS_OFF_OFFSET_1)) off1_reg <= reg_wdata[1:0];
      if (reg_wr && hit(reg_addr, LTS_OFF_CHAN)) chan_reg <= reg_wdata[LTS_CHW-1:0];
      if (reg_wr && hit(reg_addr, LTS_OFF_TIMER)) tmr_ctl_reg <= reg_wdata[1:0];
      if (reg_wr && hit(reg_addr, LTS_OFF_MASK)) mask_reg <= reg_wdata[LTS_NIRQ-1:0];
    end
  end

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        LTS_OFF_CTRL_A_LOW:  rdata_next = {24'h000000, cal_reg};
        LTS_OFF_CTRL_A_HIGH: rdata_next = {24'h000000, cah_reg};
        LTS_OFF_CTRL_B_LOW:  rdata_next = {24'h000000, cbl_reg};
        LTS_OFF_OFFSET_0:    rdata_next = {26'h0000000, off0_reg};
        LTS_OFF_OFFSET_1:    rdata_next = {30'h00000000, off1_reg};
        LTS_OFF_RESULT:      rdata_next = {16'h0000, result_reg};
        LTS_OFF_CHAN:        rdata_next = {30'h00000000, chan_reg};
        LTS_OFF_TIMER:       rdata_next = {30'h00000000, tmr_ctl_reg};
        LTS_OFF_STATUS:      rdata_next = {28'h0000000, status_reg};
        LTS_OFF_MASK:        rdata_next = {28'h0000000, mask_reg};
        LTS_OFF_STATE:       rdata_next = {27'h0000000, ch_reg, state_reg};
        default:             rdata_next = '0;
      endcase
    end
  end

  // set wins over a write-one clear in the same cycle
  assign status_next = (status_reg & ~(wr_stat ? reg_wdata[LTS_NIRQ-1:0] : '0)) | irq_set;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg  <= '0;
      status_reg <= '0;
    end else begin
      rdata_reg  <= rdata_next;
      status_reg <= status_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // interval timer and event link
  logic [31:0] tmr_cnt_reg;
  logic        tick_reg;
  wire         tmr_last = (tmr_cnt_reg == 32'(TICK_PERIOD_CYC - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tmr_cnt_reg <= '0;
      tick_reg    <= 1'b0;
    end else begin
      tmr_cnt_reg <= (!tmr_ctl_reg[LTS_TMR_RUN] || tmr_last) ? '0 : tmr_cnt_reg + 32'h1;
      tick_reg    <= tmr_ctl_reg[LTS_TMR_RUN] && tmr_last;
    end
  end

  assign interval_tick_event = tick_reg;
  wire link_trig = tick_reg && tmr_ctl_reg[LTS_TMR_LINK];

  ////////////////////////////////////////////////////////////////////////////
  // sensor unit clock, drive pulse and sense edge counting
  logic [7:0] su_cnt_reg;
  logic       su_tick_reg, su_half_reg, drive_reg;
  logic [2:0] sense_sync_reg;
  wire        pulse_tick = su_tick_reg && (su_drive || su_half_reg);
  wire        drive_rise = pulse_tick && !drive_reg;
  wire        sense_rise = sense_sync_reg[1] && !sense_sync_reg[2];
  wire        su_last    = (su_cnt_reg == 8'(LTS_SENSOR_UNIT_CLOCK_HALF_CYC - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      su_cnt_reg     <= '0;
      su_tick_reg    <= 1'b0;
      su_half_reg    <= 1'b0;
      drive_reg      <= 1'b0;
      sense_sync_reg <= '0;
    end else begin
      su_cnt_reg     <= su_last ? '0 : su_cnt_reg + 8'h1;
      su_tick_reg    <= su_last;
      su_half_reg    <= su_half_reg ^ su_tick_reg;
      drive_reg      <= pulse_tick ? !drive_reg : drive_reg;
      sense_sync_reg <= {sense_sync_reg[1:0], sense_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer
  logic [7:0] settle_cnt_reg, settle_next, pcnt_reg, pcnt_next;
  wire busy     = (state_reg != LTS_ST_IDLE) && (state_reg != LTS_ST_WAIT);
  wire trig_ok  = link_trig && sw_trig && (!cpu_stopped || sleep_en);
  wire ch_last  = !scan_multi || (ch_reg == chan_reg);
  wire settle_done = su_tick_reg && (settle_cnt_reg == cbl_reg);
  wire count_done  = (meas_n == 8'h00) || (drive_rise && (pcnt_reg == meas_n - 8'h01));
  wire scan_done   = (state_reg == LTS_ST_RDREQ) && rd_res && ch_last;
  wire [LTS_CHW-1:0] first_ch = scan_multi ? LTS_CHW'(0) : chan_reg;
  assign sw_scan_end = scan_done && !sw_trig;

  always_comb begin
    state_next  = state_reg;
    ch_next     = ch_reg;
    settle_next = settle_cnt_reg;
    pcnt_next   = pcnt_reg;
    result_next = result_reg;
    unique case (state_reg)
      LTS_ST_IDLE: begin
        ch_next = first_ch;
        if (cal_reg[LTS_CAL_START]) state_next = sw_trig ? LTS_ST_WAIT : LTS_ST_WRREQ;
      end
      LTS_ST_WAIT: begin
        ch_next = first_ch;
        if (trig_ok) state_next = LTS_ST_WRREQ;
      end
      LTS_ST_WRREQ: begin
        settle_next = '0;
        if (wr_off0) state_next = LTS_ST_SETTLE;
      end
      LTS_ST_SETTLE: begin
        pcnt_next   = '0;
        result_next = '0;
        if (su_tick_reg) settle_next = settle_cnt_reg + 8'h01;
        if (settle_done) state_next = LTS_ST_COUNT;
      end
      LTS_ST_COUNT: begin
        if (drive_rise) pcnt_next = pcnt_reg + 8'h01;
        if (sense_rise && !(&result_reg)) result_next = result_reg + 16'h0001;
        if (count_done) state_next = LTS_ST_RDREQ;
      end
      LTS_ST_RDREQ: begin
        if (rd_res) begin
          if (ch_last) begin
            state_next = sw_trig ? LTS_ST_WAIT : LTS_ST_IDLE;
          end else begin
            state_next = LTS_ST_WRREQ;
            ch_next    = ch_reg + LTS_CHW'(1);
          end
        end
      end
      default: state_next = LTS_ST_IDLE;
    endcase
    if (!cal_reg[LTS_CAL_START]) state_next = LTS_ST_IDLE;
  end

  logic wrreq_reg, rdreq_reg, end_reg, sleep_run_reg, boost_reg;
  wire  enter_wr = (state_next == LTS_ST_WRREQ) && (state_reg != LTS_ST_WRREQ);
  wire  enter_rd = (state_next == LTS_ST_RDREQ) && (state_reg != LTS_ST_RDREQ);
  wire  scanning = (state_reg == LTS_ST_SETTLE) || (state_reg == LTS_ST_COUNT);

  assign irq_set = {link_trig && busy, enter_rd, enter_wr, scan_done};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= LTS_ST_IDLE;
      ch_reg         <= '0;
      settle_cnt_reg <= '0;
      pcnt_reg       <= '0;
      result_reg     <= '0;
      wrreq_reg      <= 1'b0;
      rdreq_reg      <= 1'b0;
      end_reg        <= 1'b0;
      sleep_run_reg  <= 1'b0;
      boost_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      ch_reg         <= ch_next;
      settle_cnt_reg <= settle_next;
      pcnt_reg       <= pcnt_next;
      result_reg     <= result_next;
      wrreq_reg      <= enter_wr;
      rdreq_reg      <= enter_rd;
      end_reg        <= scan_done;
      sleep_run_reg  <= (state_next != LTS_ST_IDLE) && (state_next != LTS_ST_WAIT) && cpu_stopped;
      boost_reg      <= cal_reg[LTS_CAL_BOOST] && (state_next == LTS_ST_SETTLE ||
                                                   state_next == LTS_ST_COUNT);
    end
  end

  assign setting_write_request = wrreq_reg;
  assign result_read_request   = rdreq_reg;
  assign measure_end_irq       = end_reg;
  assign sleep_peripheral_run  = sleep_run_reg;
  assign boost_on              = boost_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sensor pins
  logic [LTS_NCH-1:0] pin_out_next, pin_oe_next, pin_out_reg, pin_oe_reg;

  for (genvar g = 0; g < LTS_NCH; g++) begin : g_pin
    wire meas = scanning && (ch_reg == LTS_CHW'(g));
    assign pin_out_next[g] = (meas || idle_sel == LTS_IDLE_PULSE) ? drive_reg :
                             (idle_sel == LTS_IDLE_HIGH);
    assign pin_oe_next[g]  = scanning && (meas ? !method_mut : (idle_sel != LTS_IDLE_HIZ));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign ts_out = pin_out_reg;
  assign ts_oe  = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_tick_period;
    @(posedge clk_sys) disable iff (!rstn)
    interval_tick_event |-> $past(tmr_last) && $past(tmr_ctl_reg[LTS_TMR_RUN]);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick off period end");

  property p_link_start;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_WAIT && link_trig && sw_trig && cal_reg[LTS_CAL_START] &&
      (!cpu_stopped || sleep_en)
      |=> state_reg == LTS_ST_WRREQ ##0 setting_write_request;
  endproperty
  a_link_start: assert property (p_link_start) else $error("linked tick did not start scan");

  property p_self_drive;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_COUNT && !method_mut |=> ts_oe[$past(ch_reg)] &&
      ts_out[$past(ch_reg)] == $past(drive_reg);
  endproperty
  a_self_drive: assert property (p_self_drive) else $error("measured pin not driven");

  property p_multi_next;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_RDREQ && rd_res && !ch_last && cal_reg[LTS_CAL_START]
      |=> state_reg == LTS_ST_WRREQ && ch_reg == $past(ch_reg) + LTS_CHW'(1);
  endproperty
  a_multi_next: assert property (p_multi_next) else $error("next channel not taken");

  property p_trig_only;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_WAIT && !trig_ok |=> state_reg inside {LTS_ST_WAIT, LTS_ST_IDLE};
  endproperty
  a_trig_only: assert property (p_trig_only) else $error("scan left wait without trigger");

  property p_sleep_block;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_WAIT && cpu_stopped && !sleep_en |=> !setting_write_request;
  endproperty
  a_sleep_block: assert property (p_sleep_block) else $error("scan ran in stop without enable");

  property p_boost;
    @(posedge clk_sys) disable iff (!rstn)
    boost_on |-> scanning && $past(cal_reg[LTS_CAL_BOOST]);
  endproperty
  a_boost: assert property (p_boost) else $error("boost on outside measurement");

  property p_idle_low;
    @(posedge clk_sys) disable iff (!rstn)
    scanning && idle_sel == LTS_IDLE_LOW ##1 ts_oe != '0
      |-> (ts_out & ~(LTS_NCH'(1) << $past(ch_reg))) == '0;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle pin not low");

  property p_su_drive;
    @(posedge clk_sys) disable iff (!rstn)
    su_drive && su_tick_reg |=> drive_reg != $past(drive_reg);
  endproperty
  a_su_drive: assert property (p_su_drive) else $error("drive not on sensor clock");

  property p_settle;
    @(posedge clk_sys) disable iff (!rstn)
    state_reg == LTS_ST_SETTLE && cal_reg[LTS_CAL_START] && su_tick_reg &&
      settle_cnt_reg == cbl_reg |=> state_reg == LTS_ST_COUNT;
  endproperty
  a_settle: assert property (p_settle) else $error("settle wait length wrong");

  property p_end_irq;
    @(posedge clk_sys) disable iff (!rstn)
    measure_end_irq |-> status_reg[LTS_IRQ_END] && state_reg inside {LTS_ST_WAIT, LTS_ST_IDLE};
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("end irq without standby");

  property p_drop;
    @(posedge clk_sys) disable iff (!rstn)
    busy && link_trig |=> status_reg[LTS_IRQ_DROP];
  endproperty
  a_drop: assert property (p_drop) else $error("busy trigger not flagged");

  c_scan_end:  cover property (@(posedge clk_sys) disable iff (!rstn) measure_end_irq);
  c_multi:     cover property (@(posedge clk_sys) disable iff (!rstn)
                               state_reg == LTS_ST_RDREQ && rd_res && !ch_last);
  c_drop:      cover property (@(posedge clk_sys) disable iff (!rstn) busy && link_trig);
  c_sleep_run: cover property (@(posedge clk_sys) disable iff (!rstn) sleep_peripheral_run);

endmodule

`default_nettype wire

// ==== lts_xfer_model.sv ====
// lts_xfer_model: transfer controller and sensor comparator facing the scan controller
// assumes the bench merges these register strobes with its own onto the register port
`timescale 1ns/10ps
`default_nettype none

module lts_xfer_model
  import lts_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        setting_write_request,
  input  wire logic        result_read_request,
  output logic      [7:0]  p_addr,
  output logic      [31:0] p_wdata,
  output logic             p_wr,
  output logic             p_rd,
  output logic             sense_in,
  output int               n_reads
);
  // free-running comparator edges, unrelated to the system clock
  initial begin
    sense_in = 1'b0;
    forever #37 sense_in = ~sense_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    p_addr = 8'h00;
    p_wdata = 32'h0;
    p_wr = 1'b0;
    p_rd = 1'b0;
    n_reads = 0;
    forever begin
      @(posedge clk_sys);
      if (setting_write_request === 1'b1) begin
        // count high bits first, count low last: that write starts settling
        p_addr <= LTS_OFF_OFFSET_1;
        p_wdata <= 32'h0;
        p_wr <= 1'b1;
        @(posedge clk_sys);
        p_addr <= LTS_OFF_OFFSET_0;
        p_wdata <= 32'h7;
        @(posedge clk_sys);
        p_wr <= 1'b0;
        p_wdata <= 32'hffffffff;
      end else if (result_read_request === 1'b1) begin
        p_addr <= LTS_OFF_RESULT;
        p_rd <= 1'b1;
        @(posedge clk_sys);
        // the next channel's write request follows at once: do not lose a cycle here
        p_rd <= 1'b0;
        n_reads = n_reads + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== test_lowpower_touch_scan_control.sv ====
// test_lowpower_touch_scan_control: register-driven scan test of lts_scan_ctrl
// assumes lts_xfer_model answers the transfer requests on the shared register port
`timescale 1ns/10ps
`default_nettype none

module test_lowpower_touch_scan_control
  import lts_pkg::*;
;
  localparam int TP = 200;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        cpu_stopped = 1'b1;
  logic [7:0]  t_addr = 8'h00, p_addr;
  logic [31:0] t_wdata = 32'h0, p_wdata, reg_rdata, d;
  logic        t_wr = 1'b0, t_rd = 1'b0, p_wr, p_rd, sense_in;
  logic [3:0]  ts_out, ts_oe;
  logic        boost_on, tick, wrq, rrq, mend, slp, irq;
  logic        tick_d = 1'b0, exp_boost = 1'b1, trig_mode = 1'b1, boost_d = 1'b0;
  logic [3:0]  exp_oe = 4'hf;
  int          mismatches = 0, n_checks = 0, n_reads, nw = 0, last_nw = 0, oe_cyc = 0, n, dw;

  always #2 clk_sys = ~clk_sys;

  lts_scan_ctrl #(.TICK_PERIOD_CYC(TP)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr((p_wr | p_rd) ? p_addr : t_addr),
    .reg_wdata(p_wr ? p_wdata : t_wdata), .reg_wr(t_wr | p_wr), .reg_rd(t_rd | p_rd),
    .reg_rdata(reg_rdata), .cpu_stopped(cpu_stopped), .sense_in(sense_in),
    .ts_out(ts_out), .ts_oe(ts_oe), .boost_on(boost_on), .interval_tick_event(tick),
    .setting_write_request(wrq), .result_read_request(rrq), .measure_end_irq(mend),
    .sleep_peripheral_run(slp), .irq(irq));

  lts_xfer_model i_xfer (
    .clk_sys(clk_sys), .setting_write_request(wrq), .result_read_request(rrq),
    .p_addr(p_addr), .p_wdata(p_wdata), .p_wr(p_wr), .p_rd(p_rd), .sense_in(sense_in),
    .n_reads(n_reads));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    t_addr <= a;
    t_wdata <= v;
    t_wr <= 1'b1;
    @(posedge clk_sys);
    t_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    t_addr <= a;
    t_rd <= 1'b1;
    @(posedge clk_sys);
    t_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // per-channel monitor of pins, requests and drive window length
  always @(posedge clk_sys) begin
    tick_d <= tick;
    // boost follows the state, the pin enables follow it one cycle later
    boost_d <= boost_on;
    if (ts_oe !== 4'h0) begin
      oe_cyc++;
      if (ts_oe !== exp_oe) chk("ts_oe", 32'(exp_oe), 32'(ts_oe));
      if (boost_d !== exp_boost) chk("boost_on", 32'(exp_boost), 32'(boost_d));
      if (slp !== 1'b1) chk("sleep_run", 32'h1, 32'(slp));
    end
    if (wrq === 1'b1) begin
      if (nw == 0 && trig_mode) chk("tick_to_wrreq", 32'h1, 32'(tick_d));
      nw++;
      oe_cyc = 0;
    end
    if (rrq === 1'b1) begin
      dw = oe_cyc - (32'h1f + 1 + 7 * 2) * LTS_SENSOR_UNIT_CLOCK_HALF_CYC;
      chk("oe_window_ok", 32'h1, 32'(dw <= 4 * LTS_SENSOR_UNIT_CLOCK_HALF_CYC && dw >= -4 * LTS_SENSOR_UNIT_CLOCK_HALF_CYC));
    end
    if (mend === 1'b1) begin
      last_nw = nw;
      nw = 0;
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(LTS_OFF_STATUS, d);
    chk("status_rst", 32'h0, d);
    rd(LTS_OFF_STATE, d);
    chk("state_rst", 32'h0, d);
    rd(8'h2c, d);
    chk("unmapped", 32'h0, d);
    wr(LTS_OFF_CTRL_A_HIGH, 32'h0c);
    wr(LTS_OFF_CTRL_B_LOW, 32'h1f);
    wr(LTS_OFF_CHAN, 32'h3);
    wr(LTS_OFF_MASK, 32'h1);
    rd(LTS_OFF_CTRL_B_LOW, d);
    chk("settle_field", 32'h1f, d);
    wr(LTS_OFF_CTRL_A_LOW, 32'h02);
    wr(LTS_OFF_CTRL_A_LOW, 32'h06);
    wr(LTS_OFF_CTRL_A_LOW, 32'h2f);
    wr(LTS_OFF_TIMER, 32'h1);
    n = 0;
    while (tick !== 1'b1 && n < 3 * TP) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (tick !== 1'b1 && n < 3 * TP);
    chk("tick_period", TP, n);
    rd(LTS_OFF_STATE, d);
    chk("state_unlinked", 32'h1, d & 32'h7);
    wr(LTS_OFF_TIMER, 32'h3);
    n = 0;
    // drop the link during the last channel so that no tick restarts the unit
    while (n_reads < 3 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (20) @(posedge clk_sys);
    wr(LTS_OFF_TIMER, 32'h1);
    while (mend !== 1'b1 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    wr(LTS_OFF_TIMER, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk("wrreq_per_scan", 32'h4, last_nw);
    chk("reads_per_scan", 32'h4, n_reads);
    rd(LTS_OFF_STATE, d);
    chk("state_after", 32'h1, d & 32'h7);
    rd(LTS_OFF_STATUS, d);
    chk("status_end_drop", 32'h9, d & 32'h9);
    chk("irq_set", 32'h1, 32'(irq));
    wr(LTS_OFF_MASK, 32'h0);
    #1 chk("irq_masked", 32'h0, 32'(irq));
    wr(LTS_OFF_MASK, 32'h1);
    #1 chk("irq_unmasked", 32'h1, 32'(irq));
    wr(LTS_OFF_STATUS, 32'hf);
    #1 chk("irq_cleared", 32'h0, 32'(irq));
    rd(LTS_OFF_STATUS, d);
    chk("status_cleared", 32'h0, d);
    // software-started single scan, mutual method, boost off
    wr(LTS_OFF_CTRL_A_LOW, 32'h00);
    wr(LTS_OFF_CHAN, 32'h2);
    exp_oe = 4'hb;
    exp_boost = 1'b0;
    trig_mode = 1'b0;
    wr(LTS_OFF_CTRL_A_LOW, 32'h11);
    n = 0;
    while (mend !== 1'b1 && n < 8000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    chk("wrreq_single", 32'h1, last_nw);
    chk("reads_total", 32'h5, n_reads);
    rd(LTS_OFF_STATE, d);
    chk("state_sw_end", 32'h10, d);
    rd(LTS_OFF_CTRL_A_LOW, d);
    chk("start_cleared", 32'h10, d);
    end_sim();
  end
endmodule

`default_nettype wire
